// file: rtl/flash_prot_pkg.sv
// Contract
// R1 - Protect pin low clears control, block select
// R2 - Any reset or standby clears, protects all
// R3 - Unlock bit zero protects every block
// R4 - Erase allowed only for selected blocks
// R5 - Overlay select set protects all blocks
// R6 - Software protection blocks program/erase entry
// R7 - Error sets flag, enters error protection
// R8 - Error keeps registers, aborts active mode
// R9 - Error blocks re-entry to program/erase
// R10 - Verify bits still settable during error
// R11 - Array read while active sets error
// R12 - Non-reset exception while active sets error
// R13 - Sleep while active sets error
// R14 - Bus release while active sets error
// R15 - Only power-on or hardware standby clear error
// R16 - Mode enabled only when all permissions hold
package flash_prot_pkg;
    // Byte addresses of the register words
    localparam logic [7:0] CTRL1_OFF = 8'h00;
    localparam logic [7:0] CTRL2_OFF = 8'h04;
    localparam logic [7:0] EBSEL_OFF = 8'h08;
    localparam logic [7:0] OVL_OFF = 8'h0c;
    localparam logic [7:0] STAT_OFF = 8'h10;
    localparam logic [7:0] IMASK_OFF = 8'h14;
    // Control register 1 bit positions
    localparam int UNLOCK_BIT = 6;
    localparam int ESU_BIT = 5;
    localparam int PSU_BIT = 4;
    localparam int EV_BIT = 3;
    localparam int PV_BIT = 2;
    localparam int E_BIT = 1;
    localparam int P_BIT = 0;
    // Reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] EBSEL_RST = 8'h00;
    localparam logic [2:0] STAT_RST = 3'h0;
    // Status bit positions
    localparam int ST_ERR = 0;
    localparam int ST_PENT = 1;
    localparam int ST_EENT = 2;
    // Error cause inputs travel together
    typedef struct packed {
        logic array_read;
        logic exception;
        logic sleep;
        logic bus_release;
    } err_evt_t;
    // Operating state
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PROG = 4'b0010,
        ST_ERASE = 4'b0100,
        ST_ERRP = 4'b1000
    } mode_t;
endpackage

// file: rtl/flash_program_erase_protection.sv
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module flash_program_erase_protection (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESETN_IN,
    // Reset and standby causes
    input wire logic POWER_ON_RESET_IN,
    input wire logic OTHER_RESET_IN,
    input wire logic SOFT_STANDBY_IN,
    input wire logic HW_STANDBY_IN,
    input wire logic FLASH_WRITE_PROTECT_PIN_N_IN,
    // Error causes from the core
    input wire flash_prot_pkg::err_evt_t ERR_EVT_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Flash array controls
    output logic PROGRAM_MODE_OUT,
    output logic ERASE_MODE_OUT,
    output logic PROG_VERIFY_OUT,
    output logic ERASE_VERIFY_OUT,
    output logic [7:0] ERASE_BLOCKS_OUT,
    output logic IRQ_OUT
);
    import flash_prot_pkg::*;

    // Registers
    logic [7:0] flash_control_reg1_r;
    logic [7:0] erase_block_select_reg1_r;
    logic ram_overlay_select_r;
    logic flash_error_flag_r;
    logic [2:0] stat_r;
    logic [2:0] mask_r;
    logic [31:0] rdata_r;
    mode_t state_r, state_nxt;

    // Bus decode
    wire access = PSEL_IN & PENABLE_IN;
    wire wr = access & PWRITE_IN;
    wire rd = access & ~PWRITE_IN;
    wire hit_c1 = PADDR_IN == CTRL1_OFF;
    wire hit_c2 = PADDR_IN == CTRL2_OFF;
    wire hit_eb = PADDR_IN == EBSEL_OFF;
    wire hit_ov = PADDR_IN == OVL_OFF;
    wire hit_st = PADDR_IN == STAT_OFF;
    wire hit_mk = PADDR_IN == IMASK_OFF;
    wire mapped = hit_c1 | hit_c2 | hit_eb | hit_ov | hit_st | hit_mk;

    // Clears: protect pin, any reset, any standby
    wire init_regs = ~FLASH_WRITE_PROTECT_PIN_N_IN | POWER_ON_RESET_IN | OTHER_RESET_IN |
                     SOFT_STANDBY_IN | HW_STANDBY_IN; // see R1 see R2
    // Only power-on reset or hardware standby clears the error
    wire err_clear = POWER_ON_RESET_IN | HW_STANDBY_IN; // see R15
    wire active = state_r == ST_PROG || state_r == ST_ERASE;
    // Any illegal event while programming or erasing
    wire err_evt = active & ~err_clear & (ERR_EVT_IN.array_read | ERR_EVT_IN.exception |
                   ERR_EVT_IN.sleep | ERR_EVT_IN.bus_release); // see R11 see R12 see R13 see R14

    // Software protection terms
    wire unlock = flash_control_reg1_r[UNLOCK_BIT]; // see R3
    wire sw_ok = unlock & ~ram_overlay_select_r & ~init_regs; // see R5 see R6
    // Erase needs a nonzero selection; program ignores it
    wire blk_ok = |erase_block_select_reg1_r; // see R4
    wire prog_ok = sw_ok & ~flash_error_flag_r & flash_control_reg1_r[P_BIT]; // see R16
    wire erase_ok = sw_ok & ~flash_error_flag_r & blk_ok & flash_control_reg1_r[E_BIT]; // see R16 see R9

    // Next mode
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (prog_ok) begin
                    state_nxt = ST_PROG;
                end else if (erase_ok) begin
                    state_nxt = ST_ERASE;
                end
            end
            ST_PROG: begin
                if (err_evt) begin
                    state_nxt = ST_ERRP; // see R7 see R8
                end else if (!prog_ok) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ERASE: begin
                if (err_evt) begin
                    state_nxt = ST_ERRP; // see R7 see R8
                end else if (!erase_ok) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ERRP: begin
                // Stays until the error flag is cleared
                if (err_clear) begin
                    state_nxt = ST_IDLE; // see R15
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Control registers; error keeps contents
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            flash_control_reg1_r <= CTRL1_RST;
            erase_block_select_reg1_r <= EBSEL_RST;
            ram_overlay_select_r <= 1'b0;
            mask_r <= STAT_RST;
        end else if (init_regs) begin
            flash_control_reg1_r <= CTRL1_RST; // see R1 see R2
            erase_block_select_reg1_r <= EBSEL_RST;
        end else if (wr) begin
            // Verify bits stay writable in error protection
            if (hit_c1) begin
                flash_control_reg1_r <= PWDATA_IN[7:0]; // see R10
            end
            if (hit_eb) begin
                erase_block_select_reg1_r <= PWDATA_IN[7:0];
            end
            if (hit_ov) begin
                ram_overlay_select_r <= PWDATA_IN[0];
            end
            if (hit_mk) begin
                mask_r <= PWDATA_IN[2:0];
            end
        end
    end

    // Error flag and mode state; software cannot clear the flag
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            flash_error_flag_r <= 1'b0;
            state_r <= ST_IDLE;
        end else begin
            flash_error_flag_r <= err_evt | (flash_error_flag_r & ~err_clear); // see R7 see R15
            state_r <= state_nxt;
        end
    end

    // Sticky status: set wins over read clear
    wire [2:0] stat_set = {state_nxt == ST_ERASE && state_r != ST_ERASE,
                           state_nxt == ST_PROG && state_r != ST_PROG, err_evt};
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            stat_r <= STAT_RST;
        end else begin
            // Clear only the bits the reader was shown; an event after the setup capture stays
            stat_r <= stat_set | (stat_r & ~(rdata_r[2:0] & {3{rd & hit_st}}));
        end
    end

    // Read data mux
    wire [31:0] rmux = hit_c1 ? {24'h0, flash_control_reg1_r} :
                       hit_c2 ? {31'h0, flash_error_flag_r} :
                       hit_eb ? {24'h0, erase_block_select_reg1_r} :
                       hit_ov ? {31'h0, ram_overlay_select_r} :
                       hit_st ? {29'h0, stat_r} :
                       hit_mk ? {29'h0, mask_r} : 32'h0;
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rdata_r <= 32'h0;
        end else if (PSEL_IN & ~PENABLE_IN) begin
            rdata_r <= rmux;
        end
    end

    // Bus answers in the first access cycle
    assign PRDATA_OUT = rdata_r;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = access & ~mapped;
    // Mode outputs drop on the clock edge after an error
    assign PROGRAM_MODE_OUT = state_r == ST_PROG; // see R8
    assign ERASE_MODE_OUT = state_r == ST_ERASE;
    assign PROG_VERIFY_OUT = flash_control_reg1_r[PV_BIT] & unlock; // see R10
    assign ERASE_VERIFY_OUT = flash_control_reg1_r[EV_BIT] & unlock;
    assign ERASE_BLOCKS_OUT = erase_block_select_reg1_r;
    assign IRQ_OUT = |(stat_r & mask_r);
endmodule

// file: bench/flash_prot_checker.sv
`timescale 1ns/1ps
module flash_prot_checker (
    input wire logic CLK_SYS_IN, RESETN_IN, POWER_ON_RESET_IN, OTHER_RESET_IN,
    input wire logic SOFT_STANDBY_IN, HW_STANDBY_IN, FLASH_WRITE_PROTECT_PIN_N_IN,
    input wire flash_prot_pkg::err_evt_t ERR_EVT_IN,
    input wire logic PSEL_IN, PENABLE_IN, PREADY_OUT, PSLVERR_OUT,
    input wire logic [7:0] PADDR_IN, ERASE_BLOCKS_OUT,
    input wire logic PROGRAM_MODE_OUT, ERASE_MODE_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);
    wire act = PROGRAM_MODE_OUT | ERASE_MODE_OUT; // Either array mode live
    wire clr = POWER_ON_RESET_IN | OTHER_RESET_IN | SOFT_STANDBY_IN | HW_STANDBY_IN;
    logic err_r; // Error protection as the device must hold it
    // Only a full clear drops it, so other resets cannot hide a fault
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
        if (!RESETN_IN) err_r <= 1'b0;
        else if (POWER_ON_RESET_IN | HW_STANDBY_IN) err_r <= 1'b0;
        else if (act & |ERR_EVT_IN) err_r <= 1'b1;
    sequence s_live_err; act && |ERR_EVT_IN; endsequence
    property p_wp; !FLASH_WRITE_PROTECT_PIN_N_IN [*3] |-> !act && ERASE_BLOCKS_OUT == 8'h00; endproperty
    property p_rst; clr [*3] |-> !act && ERASE_BLOCKS_OUT == 8'h00; endproperty
    property p_blk; (ERASE_BLOCKS_OUT == 8'h00) [*3] |-> !ERASE_MODE_OUT; endproperty
    property p_abort; s_live_err |=> !act; endproperty
    property p_hold; err_r |-> !act; endproperty
    property p_one; !(PROGRAM_MODE_OUT && ERASE_MODE_OUT); endproperty
    property p_rdy; PSEL_IN && PENABLE_IN |-> PREADY_OUT; endproperty
    property p_err; PSEL_IN && PENABLE_IN && PADDR_IN > 8'h14 |-> PSLVERR_OUT; endproperty
    a_wp: assert property (p_wp)
        else $error("mode live under protect pin");
    a_rst: assert property (p_rst)
        else $error("mode live during clear");
    a_blk: assert property (p_blk)
        else $error("erase with no block");
    a_abort: assert property (p_abort)
        else $error("mode kept after error");
    a_hold: assert property (p_hold)
        else $error("mode re-entered after error");
    a_one: assert property (p_one)
        else $error("both modes live");
    a_rdy: assert property (p_rdy)
        else $error("no ready in access");
    a_err: assert property (p_err)
        else $error("no slave error on hole");
endmodule

// file: bench/cpu_err_model.sv
`timescale 1ns/1ps
module cpu_err_model (
    input wire logic clk_in,
    input wire logic [3:0] req_in,
    output flash_prot_pkg::err_evt_t evt_out
);
    initial evt_out = '0;
    // Core raises a cause a clock after the request, for as long as the request is held
    always @(posedge clk_in) evt_out <= req_in;
endmodule

// file: bench/flash_program_erase_protection_tb.sv
`timescale 1ns/1ps
module flash_program_erase_protection_tb;
    import flash_prot_pkg::*;
    logic clk = 0, rstn = 0, wp_n = 1, psel = 0, pen = 0, pw = 0;
    logic [3:0] rs = 0, req = 0; // Clears: por, other, soft, hw
    logic [7:0] pa = 0;
    logic [31:0] pwd = 0, rd;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, pm, em, pv, ev, irq;
    wire logic [7:0] blk;
    err_evt_t evt;
    int num_errors = 0, n_tests = 0;
    always #12.5 clk = ~clk;
    flash_program_erase_protection flash_program_erase_protection_i(.CLK_SYS_IN(clk), .RESETN_IN(rstn),
        .POWER_ON_RESET_IN(rs[3]), .OTHER_RESET_IN(rs[2]), .SOFT_STANDBY_IN(rs[1]), .HW_STANDBY_IN(rs[0]),
        .FLASH_WRITE_PROTECT_PIN_N_IN(wp_n), .ERR_EVT_IN(evt), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .PROGRAM_MODE_OUT(pm), .ERASE_MODE_OUT(em), .PROG_VERIFY_OUT(pv),
        .ERASE_VERIFY_OUT(ev), .ERASE_BLOCKS_OUT(blk), .IRQ_OUT(irq));
    cpu_err_model cpu_err_model_i(.clk_in(clk), .req_in(req), .evt_out(evt));
    task automatic chk(input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One APB transfer; holes above the map must answer with an error
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); psel <= 1; pen <= 0; pw <= w; pa <= a; pwd <= d;
        @(posedge clk); pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        chk(pslverr, a > 8'h14);
        psel <= 0; pen <= 0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Three cycles, long enough for the mode state to settle
    task automatic pulse(input int b);
        @(posedge clk) rs[b] <= 1;
        repeat (3) @(posedge clk);
        rs[b] <= 0;
        idle(2);
    endtask
    task automatic complete_run;
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Tests need about 320 cycles; allow some 25 times that
    initial begin
        #200us; num_errors++; complete_run;
    end
    initial begin
        repeat (10) @(posedge clk); rstn <= 1;
        apb(0, CTRL1_OFF, 0); chk(rd, CTRL1_RST);
        apb(0, EBSEL_OFF, 0); chk(rd, EBSEL_RST);
        apb(0, 8'h20, 0); chk(rd, 0);
        apb(1, CTRL1_OFF, 8'h01); idle(3); chk(pm, 0);
        apb(1, OVL_OFF, 1); apb(1, CTRL1_OFF, 8'h41); idle(3); chk(pm, 0);
        apb(1, CTRL1_OFF, 8'h40); apb(1, OVL_OFF, 0);
        apb(1, CTRL1_OFF, 8'h42); idle(3); chk(em, 0);
        $display("test soft protection done");
        for (int b = 0; b < 4; b++) begin
            apb(1, EBSEL_OFF, 8'h04); apb(1, CTRL1_OFF, 8'h42); idle(3); chk(em, 1);
            pulse(b); chk(em, 0); chk(blk, 0);
        end
        apb(1, EBSEL_OFF, 8'h04); apb(1, CTRL1_OFF, 8'h42);
        @(posedge clk) wp_n <= 0;
        idle(3); chk(em, 0); chk(blk, 0);
        apb(1, CTRL1_OFF, 8'h41); apb(0, CTRL1_OFF, 0); chk(rd, 0);
        @(posedge clk) wp_n <= 1;
        $display("test clears done");
        for (int k = 0; k < 4; k++) begin
            pulse(3);
            apb(1, IMASK_OFF, k != 3); apb(1, CTRL1_OFF, 8'h41); idle(3); chk(pm, 1);
            @(posedge clk) req <= 4'h1 << k;
            @(posedge clk) req <= 0;
            idle(3); chk(pm, 0); chk(irq, k != 3);
            apb(0, CTRL2_OFF, 0); chk(rd, 1);
            apb(0, CTRL1_OFF, 0); chk(rd, 8'h41);
            apb(1, CTRL1_OFF, 8'h4d); idle(3); chk(pm, 0); chk(pv, 1);
            chk(ev, 1);
            apb(0, STAT_OFF, 0); chk(rd[ST_ERR], 1); idle(2); chk(irq, 0);
            pulse(2); apb(0, CTRL2_OFF, 0); chk(rd, 1);
        end
        pulse(3); apb(0, CTRL2_OFF, 0); chk(rd, 0);
        $display("test errors done");
        complete_run;
    end
endmodule
bind flash_program_erase_protection flash_prot_checker flash_prot_checker_i(.*);
